// ### common/sysctl_pkg.sv
// Package: coprocessor system control register map, fields, reset values
// Summary of operation
// [RULE1] Software writes reserved bits fixed or read-modify-write
// [RULE2] Reset clears all defined control bits
// [RULE3] Vector bit loads from strap at reset
// [RULE4] Bits 31:30 select clocking mode
// [RULE5] Bit 14 picks random or round-robin replacement
// [RULE6] Bit 13 picks low or high vectors
// [RULE7] Bits 12 and 2 enable caches
// [RULE8] Bits 9:8 modify MMU protection checks
// [RULE9] Bit 7 selects big-endian
// [RULE10] Bit 1 enables alignment fault checking
// [RULE11] Software enables MMU from stable mapping
// [RULE12] Table base keeps bits 31:14 only
// [RULE13] Domain register holds sixteen two-bit fields
// [RULE14] Software never accesses register four
// [RULE15] Data fault records domain and type
// [RULE16] Fault status bit 8 reads zero
// [RULE17] Separate pipelined prefetch fault status, opcode2 one
// [RULE18] Fault address captured on data faults only
// [RULE19] Fault registers writable for debugger restore
// [RULE20] Registers selected by opcode1, primary, secondary, opcode2
// [RULE21] Only privileged transfers accepted, others trap
// [RULE22] Writes act next instruction, reads return latest
package sysctl_pkg;
    // Primary register numbers
    localparam logic [3:0]  REG_CONTROL   = 4'h1;
    localparam logic [3:0]  REG_TABLE     = 4'h2;
    localparam logic [3:0]  REG_DOMAIN    = 4'h3;
    localparam logic [3:0]  REG_RESERVED  = 4'h4;
    localparam logic [3:0]  REG_FSTATUS   = 4'h5;
    localparam logic [3:0]  REG_FADDR     = 4'h6;
    localparam logic [3:0]  SEC_ZERO      = 4'h0;
    localparam logic [2:0]  OP1_ZERO      = 3'h0;
    localparam logic [2:0]  OP2_DATA      = 3'h0;
    localparam logic [2:0]  OP2_PREFETCH  = 3'h1;
    // Control field positions
    localparam int CTL_ASYNC = 31;
    localparam int CTL_NFAST = 30;
    localparam int CTL_RR    = 14;
    localparam int CTL_VEC   = 13;
    localparam int CTL_ICACHE = 12;
    localparam int CTL_ROMP  = 9;
    localparam int CTL_SYSP  = 8;
    localparam int CTL_BIG   = 7;
    localparam int CTL_DCACHE = 2;
    localparam int CTL_ALIGN = 1;
    localparam int CTL_MMU   = 0;
    // Writable masks and fixed read values
    localparam logic [31:0] CTL_WMASK     = 32'hc000_7387;
    localparam logic [31:0] CTL_FIXED_ONE = 32'h0000_0078;
    localparam logic [31:0] TABLE_MASK    = 32'hffff_c000;
    localparam logic [31:0] FSTATUS_MASK  = 32'h0000_00ff;
    localparam logic [31:0] RESET_ZERO    = 32'h0000_0000;
    localparam logic [31:0] VEC_LOW       = 32'h0000_0000;
    localparam logic [31:0] VEC_HIGH      = 32'hffff_0000;
    // Clocking modes
    typedef enum logic [1:0] {
        CLK_FASTBUS  = 2'b00,
        CLK_SYNC     = 2'b01,
        CLK_RESERVED = 2'b10,
        CLK_ASYNC    = 2'b11
    } clock_mode_type;
    // APB offsets of controller registers
    localparam logic [7:0]  APB_CMD    = 8'h00;
    localparam logic [7:0]  APB_WDATA  = 8'h04;
    localparam logic [7:0]  APB_RDATA  = 8'h08;
    localparam logic [7:0]  APB_STATUS = 8'h0c;
    // Command word fields
    localparam int CMD_READ = 16;
    localparam int CMD_PRIV = 17;
endpackage

// ### common/sysctl_if.sv
// Interface: coprocessor register transfer link between core and control bank
`timescale 1ns/1ps
`default_nettype none
interface sysctl_if;
    logic        req;
    logic        read;
    logic        privileged;
    logic [2:0]  opcode1;
    logic [3:0]  primary;
    logic [3:0]  secondary;
    logic [2:0]  opcode2;
    logic [31:0] wdata;
    logic        done;
    logic        undefTrap;
    logic [31:0] rdata;
    modport bank (input req, read, privileged, opcode1, primary, secondary, opcode2, wdata,
                  output done, undefTrap, rdata);
    modport core (output req, read, privileged, opcode1, primary, secondary, opcode2, wdata,
                  input done, undefTrap, rdata);
endinterface
`default_nettype wire

// ### verilog/fault_capture.sv
// Module: one fault status register with capture and debugger write
`timescale 1ns/1ps
`default_nettype none
module fault_capture
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Capture and write
    input  wire logic        capture,
    input  wire logic [3:0]  domain,
    input  wire logic [3:0]  faultType,
    input  wire logic        write,
    input  wire logic [31:0] wdata,
    // Stored value
    output logic      [31:0] value
);
    // Hardware capture wins over a coincident debugger write
    always_ff @(posedge clk or posedge rst)
        if (rst)
            value <= sysctl_pkg::RESET_ZERO;
        else if (capture)
            value <= {24'h000000, domain, faultType}; // RULE15
        else if (write)
            value <= wdata & sysctl_pkg::FSTATUS_MASK; // RULE16 RULE19
endmodule
`default_nettype wire

// ### verilog/sysctl_bank.sv
// Module: system control register bank, the device end of the link
`timescale 1ns/1ps
`default_nettype none
module sysctl_bank
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Transfer link
    sysctl_if.bank           link,
    // Strap sampled at the first clock edge after reset is released
    input  wire logic        vector_high_at_reset_pin,
    // Fault reports from the memory system
    input  wire logic        dataFault,
    input  wire logic        prefetchFault,
    input  wire logic [3:0]  faultDomain,
    input  wire logic [3:0]  faultType,
    input  wire logic [31:0] modified_virtual_address,
    // Control outputs
    output var sysctl_pkg::clock_mode_type clockMode,
    output logic             round_robin_select,
    output logic [31:0]      vectorBase,
    output logic             icacheEnable,
    output logic             dcacheEnable,
    output logic             romProtect,
    output logic             sysProtect,
    output logic             bigEndian,
    output logic             alignCheck,
    output logic             mmuEnable,
    output logic [31:0]      table_base_pointer,
    output logic [31:0]      domainAccess
);
    // Stored register images
    logic [31:0] control;
    logic [31:0] faultStatus;
    logic [31:0] prefetchStatus;
    logic [31:0] prefetchStage;
    logic        prefetchPending;
    logic [31:0] fault_address;
    // Reset helper and transfer decode
    logic        strapHold;
    logic        hit;
    logic        ok;
    logic        wr;
    logic        ctlWrite;
    logic        tableWrite;
    logic        domainWrite;
    logic        statusWrite;
    logic        prefetchWrite;
    logic        addrWrite;
    logic        taken;
    logic [31:0] next_rdata;

    // Register select; only op1 zero, secondary zero
    assign hit = link.opcode1 == sysctl_pkg::OP1_ZERO && link.secondary == sysctl_pkg::SEC_ZERO; // RULE20
    assign ok  = link.req && link.privileged && hit; // RULE21
    assign wr  = taken && ok && !link.read;

    // A held request is taken once; the answer cycle blocks a second take
    assign taken = link.req && !link.done && !link.undefTrap;

    // Per-register write strobes; register four and unknown numbers match none
    assign ctlWrite      = wr && link.primary == sysctl_pkg::REG_CONTROL && link.opcode2 == sysctl_pkg::OP2_DATA;
    assign tableWrite    = wr && link.primary == sysctl_pkg::REG_TABLE;
    assign domainWrite   = wr && link.primary == sysctl_pkg::REG_DOMAIN;
    assign statusWrite   = wr && link.primary == sysctl_pkg::REG_FSTATUS && link.opcode2 == sysctl_pkg::OP2_DATA;
    assign prefetchWrite = wr && link.primary == sysctl_pkg::REG_FSTATUS && link.opcode2 == sysctl_pkg::OP2_PREFETCH;
    assign addrWrite     = wr && link.primary == sysctl_pkg::REG_FADDR;

    // Strap read and applied at the first edge after release, while strapHold is still set
    // An async reset branch loads constants only, so the pin lands one edge late
    always_ff @(posedge clk or posedge rst)
        if (rst)
            strapHold <= 1'b1;
        else
            strapHold <= 1'b0;

    // Control register; reset clears defined bits then strap loads vector bit
    // Reserved bits are not stored; their fixed read values come from the read mux
    always_ff @(posedge clk or posedge rst)
        if (rst)
            control <= sysctl_pkg::RESET_ZERO; // RULE2
        else if (strapHold)
            control[sysctl_pkg::CTL_VEC] <= vector_high_at_reset_pin; // RULE3
        else if (ctlWrite)
            control <= link.wdata & sysctl_pkg::CTL_WMASK; // RULE22

    // Table base keeps only its upper pointer bits
    always_ff @(posedge clk or posedge rst)
        if (rst)
            table_base_pointer <= sysctl_pkg::RESET_ZERO;
        else if (tableWrite)
            table_base_pointer <= link.wdata & sysctl_pkg::TABLE_MASK; // RULE12

    // Sixteen domain fields, domain 15 in the top pair
    always_ff @(posedge clk or posedge rst)
        if (rst)
            domainAccess <= sysctl_pkg::RESET_ZERO;
        else if (domainWrite)
            domainAccess <= link.wdata; // RULE13

    // Data fault status
    fault_capture dataStatus
    (
        .clk       (clk),
        .rst       (rst),
        .capture   (dataFault),
        .domain    (faultDomain),
        .faultType (faultType),
        .write     (statusWrite),
        .wdata     (link.wdata),
        .value     (faultStatus)
    );

    // Prefetch fault goes one stage down the pipe before it lands
    // Stage loads every cycle; only the delayed pulse decides a capture
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            prefetchStage   <= sysctl_pkg::RESET_ZERO;
            prefetchPending <= 1'b0;
        end
        else
        begin
            prefetchStage   <= {24'h000000, faultDomain, faultType};
            prefetchPending <= prefetchFault; // RULE17
        end

    // Debug-only prefetch status, reached with opcode2 one
    fault_capture prefetchStatusReg
    (
        .clk       (clk),
        .rst       (rst),
        .capture   (prefetchPending),
        .domain    (prefetchStage[7:4]),
        .faultType (prefetchStage[3:0]),
        .write     (prefetchWrite),
        .wdata     (link.wdata),
        .value     (prefetchStatus)
    );

    // Fault address follows data faults only; capture beats debugger write
    // A prefetch fault address stays with the core, so it is ignored here
    always_ff @(posedge clk or posedge rst)
        if (rst)
            fault_address <= sysctl_pkg::RESET_ZERO;
        else if (dataFault)
            fault_address <= modified_virtual_address; // RULE18
        else if (addrWrite)
            fault_address <= link.wdata; // RULE19

    // Read mux; unpredictable bits returned as zero
    always_comb
    begin
        next_rdata = sysctl_pkg::RESET_ZERO;
        case (link.primary)
            sysctl_pkg::REG_CONTROL:
                next_rdata = control | sysctl_pkg::CTL_FIXED_ONE; // RULE1
            sysctl_pkg::REG_TABLE:
                next_rdata = table_base_pointer;
            sysctl_pkg::REG_DOMAIN:
                next_rdata = domainAccess;
            sysctl_pkg::REG_FSTATUS:
                next_rdata = (link.opcode2 == sysctl_pkg::OP2_PREFETCH) ? prefetchStatus : faultStatus; // RULE16
            sysctl_pkg::REG_FADDR:
                next_rdata = fault_address;
            // Register four, register zero and numbers above six read zero
            default:
                next_rdata = sysctl_pkg::RESET_ZERO; // RULE14
        endcase
    end

    // One-cycle answer: done or trap, with registered read data
    // rdata moves only on an accepted read, so it holds between reads
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            link.done      <= 1'b0;
            link.undefTrap <= 1'b0;
            link.rdata     <= sysctl_pkg::RESET_ZERO;
        end
        else
        begin
            link.done      <= taken && ok;
            link.undefTrap <= taken && !ok; // RULE21
            if (taken && ok && link.read)
                link.rdata <= next_rdata; // RULE22
        end

    // Clocking mode and replacement policy
    assign clockMode          = sysctl_pkg::clock_mode_type'(
                                    control[sysctl_pkg::CTL_ASYNC:sysctl_pkg::CTL_NFAST]); // RULE4
    assign round_robin_select = control[sysctl_pkg::CTL_RR]; // RULE5

    // Vector base and cache enables
    assign vectorBase   = control[sysctl_pkg::CTL_VEC] ? sysctl_pkg::VEC_HIGH : sysctl_pkg::VEC_LOW; // RULE6
    assign icacheEnable = control[sysctl_pkg::CTL_ICACHE]; // RULE7
    assign dcacheEnable = control[sysctl_pkg::CTL_DCACHE]; // RULE7

    // Protection modifiers and byte order
    assign romProtect   = control[sysctl_pkg::CTL_ROMP]; // RULE8
    assign sysProtect   = control[sysctl_pkg::CTL_SYSP]; // RULE8
    assign bigEndian    = control[sysctl_pkg::CTL_BIG]; // RULE9

    // Alignment checking and MMU; software must switch the MMU from a flat mapping
    assign alignCheck   = control[sysctl_pkg::CTL_ALIGN]; // RULE10
    assign mmuEnable    = control[sysctl_pkg::CTL_MMU];
endmodule
`default_nettype wire

// ### verilog/sysctl_core_master.sv
// Module: core-side transfer issuer, driven by software over APB
`timescale 1ns/1ps
`default_nettype none
module sysctl_core_master
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transfer link
    sysctl_if.core           link
);
    typedef enum logic [0:0] {
        IDLE = 1'b0,
        BUSY = 1'b1
    } state_type;
    state_type   state;
    logic [31:0] writeWord;
    logic [31:0] readWord;
    logic        trapped;
    logic        apbWrite;
    logic        known;

    assign known    = paddr == sysctl_pkg::APB_CMD || paddr == sysctl_pkg::APB_WDATA
                   || paddr == sysctl_pkg::APB_RDATA || paddr == sysctl_pkg::APB_STATUS;
    assign apbWrite = psel && penable && pwrite;
    // Always zero-wait; unmapped addresses flag an error
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !known;

    // Write data staging
    always_ff @(posedge clk or posedge rst)
        if (rst)
            writeWord <= sysctl_pkg::RESET_ZERO;
        else if (apbWrite && paddr == sysctl_pkg::APB_WDATA)
            writeWord <= pwdata;

    // Command launch; commands while busy are dropped, software polls status
    always_ff @(posedge clk or posedge rst)
        if (rst)
        begin
            state           <= IDLE;
            link.req        <= 1'b0;
            link.read       <= 1'b0;
            link.privileged <= 1'b0;
            link.opcode1    <= 3'h0;
            link.primary    <= 4'h0;
            link.secondary  <= 4'h0;
            link.opcode2    <= 3'h0;
            link.wdata      <= sysctl_pkg::RESET_ZERO;
            readWord        <= sysctl_pkg::RESET_ZERO;
            trapped         <= 1'b0;
        end
        else
        begin
            case (state)
                IDLE:
                    if (apbWrite && paddr == sysctl_pkg::APB_CMD)
                    begin
                        link.req        <= 1'b1;
                        link.read       <= pwdata[sysctl_pkg::CMD_READ];
                        link.privileged <= pwdata[sysctl_pkg::CMD_PRIV];
                        link.opcode1    <= pwdata[14:12];
                        link.primary    <= pwdata[11:8];
                        link.secondary  <= pwdata[7:4];
                        link.opcode2    <= pwdata[2:0];
                        link.wdata      <= writeWord;
                        state           <= BUSY;
                    end
                BUSY:
                    if (link.done || link.undefTrap)
                    begin
                        link.req <= 1'b0;
                        trapped  <= link.undefTrap;
                        if (link.done && link.read)
                            readWord <= link.rdata;
                        state    <= IDLE;
                    end
                default:
                    state <= IDLE;
            endcase
        end

    // Registered APB read data
    always_ff @(posedge clk or posedge rst)
        if (rst)
            prdata <= sysctl_pkg::RESET_ZERO;
        else if (psel && !penable && !pwrite)
            case (paddr)
                sysctl_pkg::APB_WDATA:  prdata <= writeWord;
                sysctl_pkg::APB_RDATA:  prdata <= readWord;
                sysctl_pkg::APB_STATUS: prdata <= {30'h00000000, trapped, state == BUSY};
                default:                prdata <= sysctl_pkg::RESET_ZERO;
            endcase
endmodule
`default_nettype wire

// ### testbench/sysctl_props.sv
// Checker: timing and read-value properties of the coprocessor transfer link
`timescale 1ns/1ps
`default_nettype none
module sysctl_props
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Link request side
    input  wire logic        req,
    input  wire logic        read,
    input  wire logic        privileged,
    input  wire logic [2:0]  opcode1,
    input  wire logic [3:0]  primary,
    input  wire logic [3:0]  secondary,
    input  wire logic [2:0]  opcode2,
    input  wire logic [31:0] wdata,
    // Link answer side
    input  wire logic        done,
    input  wire logic        undefTrap,
    input  wire logic [31:0] rdata
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic taken;
    logic legal;
    logic rdDone;

    // A request counts only while no answer is standing
    assign taken  = req && !done && !undefTrap;
    assign legal  = privileged && opcode1 == sysctl_pkg::OP1_ZERO && secondary == sysctl_pkg::SEC_ZERO;
    assign rdDone = done && read;

    accept_done_a: assert property (taken && legal |=> done && !undefTrap)
        else $error("accepted transfer not answered with done");
    refuse_trap_a: assert property (taken && !legal |=> undefTrap && !done)
        else $error("refused transfer not answered with trap");
    answer_pulse_a: assert property ((done || undefTrap) |=> !done && !undefTrap && !req)
        else $error("answer longer than one cycle or request kept");
    request_hold_a: assert property (taken |=> req && $stable({read, primary, opcode2, wdata}))
        else $error("request changed before its answer");
    rdata_hold_a: assert property ($changed(rdata) |-> rdDone)
        else $error("read data changed without a completed read");
    control_fixed_a: assert property (rdDone && primary == sysctl_pkg::REG_CONTROL |->
        rdata[6:3] == 4'hf && rdata[11:10] == 2'h0 && rdata[29:15] == 15'h0)
        else $error("control reserved bits read wrong");
    table_low_a: assert property (rdDone && primary == sysctl_pkg::REG_TABLE |-> rdata[13:0] == 14'h0)
        else $error("table base low bits not zero");
    status_upper_a: assert property (rdDone && primary == sysctl_pkg::REG_FSTATUS |-> rdata[31:8] == 24'h0)
        else $error("fault status upper bits not zero");

    // Main scenarios reached
    cover property (taken && legal && read);
    cover property (taken && legal && !read);
    cover property (undefTrap);
endmodule
`default_nettype wire

// ### testbench/system_control_fault_regs_tb.sv
// Testbench: APB-driven checks of the control register bank across its link
`timescale 1ns/1ps
`default_nettype none
module system_control_fault_regs_tb;
    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strap;
    logic        dataFault;
    logic        prefetchFault;
    logic [3:0]  faultDomain;
    logic [3:0]  faultType;
    logic [31:0] faultAddr;
    logic [1:0]  clockMode;
    logic        rrSel, icache, dcache, romProt, sysProt, bigEnd, alignChk, mmuOn;
    logic [31:0] vecBase, tableBase, domains;
    int          miscompares;
    int          compares;

    sysctl_if link ();
    sysctl_bank i_sysctl_bank (.clk(clk), .rst(rst), .link(link.bank), .vector_high_at_reset_pin(strap),
        .dataFault(dataFault), .prefetchFault(prefetchFault), .faultDomain(faultDomain), .faultType(faultType),
        .modified_virtual_address(faultAddr), .clockMode(clockMode), .round_robin_select(rrSel),
        .vectorBase(vecBase), .icacheEnable(icache), .dcacheEnable(dcache), .romProtect(romProt),
        .sysProtect(sysProt), .bigEndian(bigEnd), .alignCheck(alignChk), .mmuEnable(mmuOn),
        .table_base_pointer(tableBase), .domainAccess(domains));
    sysctl_core_master i_sysctl_core_master (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.core));
    sysctl_props i_sysctl_props (.clk(clk), .rst(rst), .req(link.req), .read(link.read),
        .privileged(link.privileged), .opcode1(link.opcode1), .primary(link.primary),
        .secondary(link.secondary), .opcode2(link.opcode2), .wdata(link.wdata), .done(link.done),
        .undefTrap(link.undefTrap), .rdata(link.rdata));

    // 200 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; an idle edge first so psel is never assigned twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Coprocessor transfer: data word, command, wait for the link answer, status, result
    task automatic cp(input logic rd, input logic priv, input logic [2:0] op1, input logic [3:0] prim,
                      input logic [2:0] op2, input logic [31:0] wd, output logic [31:0] q, output logic trap);
        logic [31:0] s;
        logic        e;
        apb(1'b1, sysctl_pkg::APB_WDATA, wd, s, e);
        apb(1'b1, sysctl_pkg::APB_CMD, {14'h0, priv, rd, 1'b0, op1, prim, 4'h0, 1'b0, op2}, s, e);
        while (link.done !== 1'b1 && link.undefTrap !== 1'b1)
            @(posedge clk);
        apb(1'b0, sysctl_pkg::APB_STATUS, 32'h0, s, e);
        trap = s[1];
        chk("busy", {31'h0, s[0]}, 32'h0);
        apb(1'b0, sysctl_pkg::APB_RDATA, 32'h0, q, e);
    endtask

    task automatic put(input logic [3:0] prim, input logic [2:0] op2, input logic [31:0] wd);
        logic [31:0] q;
        logic        t;
        cp(1'b0, 1'b1, 3'h0, prim, op2, wd, q, t);
    endtask

    task automatic get(input string what, input logic [3:0] prim, input logic [2:0] op2, input logic [31:0] exp);
        logic [31:0] q;
        logic        t;
        cp(1'b1, 1'b1, 3'h0, prim, op2, 32'h0, q, t);
        chk(what, q, exp);
    endtask

    // Control write, decoded outputs, then read back
    task automatic ctl(input logic [31:0] w);
        logic [31:0] exp;
        logic [31:0] seen;
        exp = {22'h0, w[31:30], w[14], w[12], w[9], w[8], w[7], w[2], w[1], w[0]};
        put(sysctl_pkg::REG_CONTROL, 3'h0, w);
        seen = {22'h0, clockMode, rrSel, icache, romProt, sysProt, bigEnd, dcache, alignChk, mmuOn};
        chk("controls", seen, exp);
        chk("vectors", vecBase, w[13] ? 32'hffff_0000 : 32'h0000_0000);
        get("control", sysctl_pkg::REG_CONTROL, 3'h0, w);
    endtask

    task automatic fault(input logic isData, input logic [3:0] dom, input logic [3:0] typ, input logic [31:0] va);
        @(posedge clk);
        faultDomain   <= dom;
        faultType     <= typ;
        faultAddr     <= va;
        dataFault     <= isData;
        prefetchFault <= ~isData;
        @(posedge clk);
        dataFault     <= 1'b0;
        prefetchFault <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic do_reset(input logic pin);
        strap <= pin;
        rst   <= 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // Hang guard, well past the few hundred cycles the sequence needs
    initial
    begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end

    initial
    begin
        logic [31:0] q;
        logic        t;
        rst = 1'b1;
        strap = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        dataFault = 1'b0;
        prefetchFault = 1'b0;
        faultDomain = 4'h0;
        faultType = 4'h0;
        faultAddr = 32'h0;
        miscompares = 0;
        compares = 0;
        @(posedge clk);
        do_reset(1'b1);
        chk("vector high at reset", vecBase, 32'hffff_0000);
        chk("mmu at reset", {31'h0, mmuOn}, 32'h0);
        get("control at reset", sysctl_pkg::REG_CONTROL, 3'h0, 32'h0000_2078);
        // Every clocking mode, every enable both ways
        ctl(32'hc000_73ff);
        ctl(32'h4000_527c);
        ctl(32'h8000_217b);
        ctl(32'h0000_0078);
        put(sysctl_pkg::REG_TABLE, 3'h0, 32'ha5a5_c000);
        chk("table out", tableBase, 32'ha5a5_c000);
        get("table", sysctl_pkg::REG_TABLE, 3'h0, 32'ha5a5_c000);
        put(sysctl_pkg::REG_DOMAIN, 3'h0, 32'h1b2d_e4f0);
        chk("domains out", domains, 32'h1b2d_e4f0);
        get("domains", sysctl_pkg::REG_DOMAIN, 3'h0, 32'h1b2d_e4f0);
        // Unprivileged and odd opcode1 writes must trap and change nothing
        cp(1'b0, 1'b0, 3'h0, sysctl_pkg::REG_CONTROL, 3'h0, 32'h0000_0079, q, t);
        chk("unprivileged trap", {31'h0, t}, 32'h1);
        cp(1'b0, 1'b1, 3'h2, sysctl_pkg::REG_CONTROL, 3'h0, 32'h0000_0079, q, t);
        chk("opcode1 trap", {31'h0, t}, 32'h1);
        get("control kept", sysctl_pkg::REG_CONTROL, 3'h0, 32'h0000_0078);
        // Data fault, then a prefetch fault that must not touch the data side
        fault(1'b1, 4'ha, 4'h5, 32'hdead_beef);
        get("data status", sysctl_pkg::REG_FSTATUS, 3'h0, 32'h0000_00a5);
        get("fault address", sysctl_pkg::REG_FADDR, 3'h0, 32'hdead_beef);
        fault(1'b0, 4'h3, 4'h7, 32'h1111_0000);
        get("prefetch status", sysctl_pkg::REG_FSTATUS, 3'h1, 32'h0000_0037);
        get("data status kept", sysctl_pkg::REG_FSTATUS, 3'h0, 32'h0000_00a5);
        get("address kept", sysctl_pkg::REG_FADDR, 3'h0, 32'hdead_beef);
        put(sysctl_pkg::REG_FSTATUS, 3'h0, 32'h0000_0042);
        get("status restore", sysctl_pkg::REG_FSTATUS, 3'h0, 32'h0000_0042);
        put(sysctl_pkg::REG_FSTATUS, 3'h1, 32'h0000_0019);
        get("prefetch restore", sysctl_pkg::REG_FSTATUS, 3'h1, 32'h0000_0019);
        put(sysctl_pkg::REG_FADDR, 3'h0, 32'h0000_1000);
        get("address restore", sysctl_pkg::REG_FADDR, 3'h0, 32'h0000_1000);
        apb(1'b0, 8'h40, 32'h0, q, t);
        chk("unmapped error", {31'h0, t}, 32'h1);
        // Second reset with the strap low
        do_reset(1'b0);
        chk("vector low at reset", vecBase, 32'h0000_0000);
        get("control after reset", sysctl_pkg::REG_CONTROL, 3'h0, 32'h0000_0078);
        tally_and_finish();
    end
endmodule
`default_nettype wire
